// >>> hw/pic_pkg.sv
// package: register map, source table and carriers of the interrupt controller
package pic_pkg;

    // ========================================================
    // register map
    localparam logic [7:0] ADDR_SPLIT_EN = 8'hA6;
    localparam logic [7:0] ADDR_ENABLE_LOW = 8'hA8;
    localparam logic [7:0] ADDR_PRIO_LOW = 8'hA9;
    localparam logic [7:0] ADDR_ENABLE_HIGH = 8'hB8;
    localparam logic [7:0] ADDR_PRIO_HIGH = 8'hB9;
    localparam logic [7:0] ADDR_REQ_FLAGS = 8'hC0;

    localparam logic [7:0] RST_SPLIT_EN = 8'h01;
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_PRIO = 8'h00;
    localparam logic [7:0] RST_REQ_FLAGS = 8'h00;
    localparam logic [7:0] MASK_ENABLE_LOW = 8'hBF;
    localparam logic [7:0] MASK_ENABLE_HIGH = 8'hBF;
    localparam logic [7:0] MASK_PRIO = 8'h3F;
    localparam logic [7:0] MASK_SPLIT_EN = 8'h03;

    // ========================================================
    // field positions
    localparam int EL_GLOBAL = 7;
    localparam int EL_TIMER2 = 5;
    localparam int EL_SERIAL = 4;
    localparam int EL_TIMER1 = 3;
    localparam int EL_PIN_B = 2;
    localparam int EL_TIMER0 = 1;
    localparam int EL_PIN_A = 0;
    localparam int EH_T2_EXT = 7;
    localparam int EH_WAKEUP = 5;
    localparam int EH_USB = 4;
    localparam int EH_USB_WU = 3;
    localparam int EH_SPI = 2;
    localparam int EH_RADIO = 1;
    localparam int EH_RADIO_CMD = 0;
    localparam int SP_MASTER = 1;
    localparam int SP_SLAVE = 0;
    // request flag bits share the enable_high positions, plus timer 2 overflow
    localparam int RF_T2_OVF = 6;

    // ========================================================
    // sources, in arbitration order: by group, then listed order
    localparam int NUM_SRC = 13;
    localparam int NUM_GROUP = 6;
    localparam int NUM_LEVEL = 4;
    localparam int SRC_W = 4;

    localparam logic [15:0] SRC_VECTOR [NUM_SRC] = '{
        16'h0003, 16'h004B, 16'h000B, 16'h0043, 16'h0013, 16'h0033,
        16'h0053, 16'h001B, 16'h005B, 16'h0023, 16'h0063, 16'h002B,
        16'h006B};
    localparam logic [2:0] SRC_GROUP [NUM_SRC] = '{
        3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4,
        3'h5, 3'h5};

    // ========================================================
    // carriers
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pic_bus_t;

    typedef struct packed {
        logic timer0;
        logic timer1;
        logic timer2_ovf;
        logic timer2_ext;
        logic serial_rx;
        logic serial_tx;
        logic cipher_ready_n;
        logic radio_cmd_ready;
        logic radio;
        logic spi_master_done;
        logic spi_slave_done;
        logic usb_wakeup;
        logic usb;
        logic internal_wakeup;
    } pic_src_t;

    typedef struct packed {
        logic request;
        logic [15:0] vector;
        logic [1:0] level;
    } pic_irq_t;

endpackage

// >>> hw/pic_controller.sv
// interrupt controller: source capture, enables, priority arbitration
`timescale 1ns/100ps

// Notes on behaviour
// - thirteen sources, four priority levels
// - enabled request branches core to its vector
// - fixed vector address per source
// - only higher level preempts running routine
// - serial receive and transmit share 0x0023
// - timer 2 overflow and external share 0x002B
// - spi master and slave share 0x0053, any edge
// - per-source polarity and edge sensitivity
// - global enable bit 7 gates every request to the core
// - enable_low gates pins, timers, serial
// - enable_high gates radio, spi, usb, wakeup
// - split register enables spi master and slave
// - six groups, priority bits 5:0
// - level is {high bit, low bit}
// - fixed group membership of sources
// - request flag register at 0xC0
// - wakeup, usb, spi flags auto-clear on vectoring
// - wakeup sets flag even when disabled
module pic_controller
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire pic_pkg::pic_bus_t bus,
    output logic [7:0] reg_rdata,
    input wire logic port_pin_a,
    input wire logic port_pin_b,
    input wire pic_pkg::pic_src_t src,
    output pic_pkg::pic_irq_t irq,
    input wire logic irq_ack,
    input wire logic irq_return
);

    // ========================================================
    // registers
    logic [7:0] spi_interrupt_split_enable;
    logic [7:0] interrupt_enable_low;
    logic [7:0] interrupt_enable_high;
    logic [7:0] priority_select_low;
    logic [7:0] priority_select_high;
    logic [7:0] request_flag_register;
    logic pin_a_flag;
    logic pin_b_flag;
    logic cipher_flag;

    // ========================================================
    // pin synchronisers and edge history
    logic [1:0] pin_a_sync;
    logic [1:0] pin_b_sync;
    logic pin_a_prev;
    logic pin_b_prev;
    logic cipher_prev;
    logic radio_prev;
    logic spi_m_prev;
    logic spi_s_prev;
    logic usb_wu_prev;
    logic usb_prev;
    logic wakeup_prev;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pin_a_sync <= 2'h3;
            pin_b_sync <= 2'h3;
        end
        else
        begin
            pin_a_sync <= {pin_a_sync[0], port_pin_a};
            pin_b_sync <= {pin_b_sync[0], port_pin_b};
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pin_a_prev <= 1'h1;
            pin_b_prev <= 1'h1;
            cipher_prev <= 1'h1;
            radio_prev <= 1'h0;
            spi_m_prev <= 1'h0;
            spi_s_prev <= 1'h0;
            usb_wu_prev <= 1'h0;
            usb_prev <= 1'h0;
            wakeup_prev <= 1'h0;
        end
        else
        begin
            pin_a_prev <= pin_a_sync[1];
            pin_b_prev <= pin_b_sync[1];
            cipher_prev <= src.cipher_ready_n;
            radio_prev <= src.radio;
            spi_m_prev <= src.spi_master_done;
            spi_s_prev <= src.spi_slave_done;
            usb_wu_prev <= src.usb_wakeup;
            usb_prev <= src.usb;
            wakeup_prev <= src.internal_wakeup;
        end
    end

    // ========================================================
    // event detection
    wire pin_a_fall = pin_a_prev & ~pin_a_sync[1];
    wire pin_b_fall = pin_b_prev & ~pin_b_sync[1];
    wire cipher_fall = cipher_prev & ~src.cipher_ready_n;
    wire radio_edge = radio_prev ^ src.radio;
    wire spi_m_edge = (spi_m_prev ^ src.spi_master_done)
        & spi_interrupt_split_enable[pic_pkg::SP_MASTER];
    wire spi_s_edge = (spi_s_prev ^ src.spi_slave_done)
        & spi_interrupt_split_enable[pic_pkg::SP_SLAVE];
    wire usb_wu_rise = ~usb_wu_prev & src.usb_wakeup;
    wire usb_rise = ~usb_prev & src.usb;
    wire wakeup_rise = ~wakeup_prev & src.internal_wakeup;

    // flags set by hardware regardless of interrupt enables; spi edges need the split enable
    logic [7:0] flag_set;
    assign flag_set = {src.timer2_ext, src.timer2_ovf, wakeup_rise,
        usb_rise, usb_wu_rise, spi_m_edge | spi_s_edge, radio_edge,
        src.radio_cmd_ready};

    // ========================================================
    // pending and enabled per source
    logic [pic_pkg::NUM_SRC-1:0] pending;
    logic [7:0] el;
    logic [7:0] eh;
    logic [7:0] rf;
    assign el = interrupt_enable_low;
    assign eh = interrupt_enable_high;
    assign rf = request_flag_register;
    assign pending[0] = pin_a_flag & el[pic_pkg::EL_PIN_A];
    assign pending[1] = rf[pic_pkg::EH_RADIO] & eh[pic_pkg::EH_RADIO];
    assign pending[2] = src.timer0 & el[pic_pkg::EL_TIMER0];
    assign pending[3] = rf[pic_pkg::EH_RADIO_CMD]
        & eh[pic_pkg::EH_RADIO_CMD];
    assign pending[4] = cipher_flag;
    assign pending[5] = pin_b_flag & el[pic_pkg::EL_PIN_B];
    assign pending[6] = rf[pic_pkg::EH_SPI] & eh[pic_pkg::EH_SPI];
    assign pending[7] = src.timer1 & el[pic_pkg::EL_TIMER1];
    assign pending[8] = rf[pic_pkg::EH_USB_WU] & eh[pic_pkg::EH_USB_WU];
    assign pending[9] = (src.serial_rx | src.serial_tx)
        & el[pic_pkg::EL_SERIAL];
    assign pending[10] = rf[pic_pkg::EH_USB] & eh[pic_pkg::EH_USB];
    assign pending[11] = (rf[pic_pkg::RF_T2_OVF] & el[pic_pkg::EL_TIMER2])
        | (rf[pic_pkg::EH_T2_EXT] & eh[pic_pkg::EH_T2_EXT]);
    assign pending[12] = rf[pic_pkg::EH_WAKEUP] & eh[pic_pkg::EH_WAKEUP];

    // ========================================================
    // arbitration
    function automatic logic [1:0] group_level(input logic [2:0] g,
        input logic [7:0] hi, input logic [7:0] lo);
        group_level = {hi[g], lo[g]};
    endfunction

    logic found;
    logic [pic_pkg::SRC_W-1:0] win_src;
    logic [1:0] win_level;
    always_comb
    begin
        found = 1'b0;
        win_src = '0;
        win_level = 2'h0;
        // highest level first, then lowest index; list is group ordered
        for (int lv = pic_pkg::NUM_LEVEL - 1; lv >= 0; lv--)
        begin
            for (int s = 0; s < pic_pkg::NUM_SRC; s++)
            begin
                if (!found && pending[s] && group_level(
                    pic_pkg::SRC_GROUP[s], priority_select_high,
                    priority_select_low) == 2'(lv))
                begin
                    found = 1'b1;
                    win_src = pic_pkg::SRC_W'(s);
                    win_level = 2'(lv);
                end
            end
        end
    end

    // in-service levels, one bit per level
    logic [pic_pkg::NUM_LEVEL-1:0] in_service;
    logic svc_any;
    logic [1:0] svc_level;
    always_comb
    begin
        svc_any = |in_service;
        svc_level = 2'h0;
        for (int lv = 0; lv < pic_pkg::NUM_LEVEL; lv++)
        begin
            if (in_service[lv])
            begin
                svc_level = 2'(lv);
            end
        end
    end

    wire may_preempt = !svc_any || (win_level > svc_level);
    wire next_request = found && el[pic_pkg::EL_GLOBAL]
        && may_preempt;
    wire take = irq_ack && irq.request;
    logic [pic_pkg::SRC_W-1:0] held_src;

    // one-hot of the highest level in service, for return
    logic [pic_pkg::NUM_LEVEL-1:0] svc_top;
    assign svc_top = svc_any ? (pic_pkg::NUM_LEVEL'(1) << svc_level) : '0;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            in_service <= '0;
        end
        else
        begin
            in_service <= (in_service & ~(irq_return ? svc_top : '0))
                | (take ? (pic_pkg::NUM_LEVEL'(1) << irq.level) : '0);
        end
    end

    // request to the core, recomputed every cycle while not taken
    always_ff @(posedge ref_clk)
    begin
        if (rst || take)
        begin
            irq <= '0;
            held_src <= '0;
        end
        else
        begin
            irq.request <= next_request;
            irq.vector <= pic_pkg::SRC_VECTOR[win_src];
            irq.level <= win_level;
            held_src <= win_src;
        end
    end

    // ========================================================
    // hardware clears on vectoring
    logic [7:0] auto_clear;
    always_comb
    begin
        auto_clear = 8'h00;
        if (take)
        begin
            unique case (held_src)
                4'h6: auto_clear[pic_pkg::EH_SPI] = 1'b1;
                4'h8: auto_clear[pic_pkg::EH_USB_WU] = 1'b1;
                4'hA: auto_clear[pic_pkg::EH_USB] = 1'b1;
                4'hC: auto_clear[pic_pkg::EH_WAKEUP] = 1'b1;
                default: auto_clear = 8'h00;
            endcase
        end
    end

    // ========================================================
    // register bus
    wire wr_split = bus.wr && bus.addr == pic_pkg::ADDR_SPLIT_EN;
    wire wr_el = bus.wr && bus.addr == pic_pkg::ADDR_ENABLE_LOW;
    wire wr_eh = bus.wr && bus.addr == pic_pkg::ADDR_ENABLE_HIGH;
    wire wr_pl = bus.wr && bus.addr == pic_pkg::ADDR_PRIO_LOW;
    wire wr_ph = bus.wr && bus.addr == pic_pkg::ADDR_PRIO_HIGH;
    wire wr_rf = bus.wr && bus.addr == pic_pkg::ADDR_REQ_FLAGS;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            spi_interrupt_split_enable <= pic_pkg::RST_SPLIT_EN;
            interrupt_enable_low <= pic_pkg::RST_ENABLE;
            interrupt_enable_high <= pic_pkg::RST_ENABLE;
            priority_select_low <= pic_pkg::RST_PRIO;
            priority_select_high <= pic_pkg::RST_PRIO;
        end
        else
        begin
            if (wr_split)
                spi_interrupt_split_enable <= bus.wdata
                    & pic_pkg::MASK_SPLIT_EN;
            if (wr_el)
                interrupt_enable_low <= bus.wdata & pic_pkg::MASK_ENABLE_LOW;
            if (wr_eh)
                interrupt_enable_high <= bus.wdata
                    & pic_pkg::MASK_ENABLE_HIGH;
            if (wr_pl)
                priority_select_low <= bus.wdata & pic_pkg::MASK_PRIO;
            if (wr_ph)
                priority_select_high <= bus.wdata & pic_pkg::MASK_PRIO;
        end
    end

    // flags: a new event wins over a software write or an auto clear
    logic [7:0] next_flags;
    assign next_flags = ((wr_rf ? bus.wdata : request_flag_register)
        & ~auto_clear) | flag_set;

    wire take_pin_a = take && held_src == 4'h0;
    wire take_cipher = take && held_src == 4'h4;
    wire take_pin_b = take && held_src == 4'h5;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            request_flag_register <= pic_pkg::RST_REQ_FLAGS;
            pin_a_flag <= 1'b0;
            pin_b_flag <= 1'b0;
            cipher_flag <= 1'b0;
        end
        else
        begin
            request_flag_register <= next_flags;
            pin_a_flag <= (pin_a_flag & ~take_pin_a) | pin_a_fall;
            pin_b_flag <= (pin_b_flag & ~take_pin_b) | pin_b_fall;
            cipher_flag <= (cipher_flag & ~take_cipher) | cipher_fall;
        end
    end

    logic [7:0] rd_mux;
    always_comb
    begin
        unique case (bus.addr)
            pic_pkg::ADDR_SPLIT_EN: rd_mux = spi_interrupt_split_enable;
            pic_pkg::ADDR_ENABLE_LOW: rd_mux = interrupt_enable_low;
            pic_pkg::ADDR_ENABLE_HIGH: rd_mux = interrupt_enable_high;
            pic_pkg::ADDR_PRIO_LOW: rd_mux = priority_select_low;
            pic_pkg::ADDR_PRIO_HIGH: rd_mux = priority_select_high;
            pic_pkg::ADDR_REQ_FLAGS: rd_mux = request_flag_register;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst || !bus.rd)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= rd_mux;
    end

endmodule

// >>> dv/pic_controller_monitor.sv
// checker: register port and request port relations of the controller
`timescale 1ns/100ps
module pic_controller_monitor
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire pic_pkg::pic_bus_t bus,
    input wire logic [7:0] reg_rdata,
    input wire logic port_pin_a,
    input wire logic port_pin_b,
    input wire pic_pkg::pic_src_t src,
    input wire pic_pkg::pic_irq_t irq,
    input wire logic irq_ack,
    input wire logic irq_return
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // ========================================================
    // shadow registers and in-service levels
    function automatic logic [2:0] vec_grp(input logic [15:0] v);
        case (v)
            16'h0003, 16'h004B: vec_grp = 3'h0;
            16'h000B, 16'h0043, 16'h0013: vec_grp = 3'h1;
            16'h0033, 16'h0053: vec_grp = 3'h2;
            16'h001B, 16'h005B: vec_grp = 3'h3;
            16'h0023, 16'h0063: vec_grp = 3'h4;
            16'h002B, 16'h006B: vec_grp = 3'h5;
            default: vec_grp = 3'h7;
        endcase
    endfunction
    logic [7:0] m_a6, m_a8, m_a9, m_b8, m_b9;
    logic [3:0] busy;
    wire logic take = irq_ack && irq.request;
    wire logic [2:0] grp = vec_grp(irq.vector);
    wire logic [1:0] lvl = {m_b9[grp], m_a9[grp]};
    wire logic [3:0] top = busy[3] ? 4'h8 : busy[2] ? 4'h4 :
        busy[1] ? 4'h2 : busy[0] ? 4'h1 : 4'h0;
    wire logic [3:0] next_busy = (busy & ~(irq_return ? top : 4'h0)) |
        (take ? 4'h1 << irq.level : 4'h0);
    wire logic [7:0] rb = (bus.addr == 8'hA6) ? m_a6 :
        (bus.addr == 8'hA8) ? m_a8 : (bus.addr == 8'hA9) ? m_a9 :
        (bus.addr == 8'hB8) ? m_b8 : (bus.addr == 8'hB9) ? m_b9 : 8'h00;
    wire logic wr_go = bus.wr && !rst;
    always_ff @(posedge ref_clk)
    begin
        m_a6 <= rst ? 8'h01 :
            (wr_go && bus.addr == 8'hA6) ? bus.wdata & 8'h03 : m_a6;
        m_a8 <= rst ? 8'h00 :
            (wr_go && bus.addr == 8'hA8) ? bus.wdata & 8'hBF : m_a8;
        m_a9 <= rst ? 8'h00 :
            (wr_go && bus.addr == 8'hA9) ? bus.wdata & 8'h3F : m_a9;
        m_b8 <= rst ? 8'h00 :
            (wr_go && bus.addr == 8'hB8) ? bus.wdata & 8'hBF : m_b8;
        m_b9 <= rst ? 8'h00 :
            (wr_go && bus.addr == 8'hB9) ? bus.wdata & 8'h3F : m_b9;
        busy <= rst ? 4'h0 : next_busy;
    end

    // ========================================================
    // assertions
    a_rdata_idle: assert property (!bus.rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_reg_readback: assert property (
        bus.rd && bus.addr != 8'hC0 |=> reg_rdata == $past(rb))
        else $error("register read differs from written value");
    a_reserved_zero: assert property (
        bus.rd && (bus.addr == 8'hA9 || bus.addr == 8'hB9)
        |=> reg_rdata[7:6] == 2'h0)
        else $error("unused priority bits read nonzero");
    a_global_gate: assert property (!$past(m_a8[7]) |-> !irq.request)
        else $error("request while globally disabled");
    a_vector_legal: assert property (irq.request |-> grp != 3'h7)
        else $error("request with unknown vector");
    a_level_match: assert property (
        irq.request && !$past(bus.wr) |-> irq.level == lvl)
        else $error("request level differs from group level");
    a_ack_clears: assert property (take |=> !irq.request)
        else $error("request stays after acknowledge");
    a_preempt_only: assert property (
        irq.request && !$past(irq_ack) && !$past(irq_return)
        |-> (4'h1 << irq.level) > top)
        else $error("request not above level in service");

    c_taken: cover property (take);
    c_nested: cover property (take && busy != 4'h0);
    c_read: cover property (bus.rd ##1 reg_rdata != 8'h00);
endmodule

bind pic_controller pic_controller_monitor i_pic_controller_monitor (
    .ref_clk(ref_clk), .rst(rst), .bus(bus), .reg_rdata(reg_rdata),
    .port_pin_a(port_pin_a), .port_pin_b(port_pin_b), .src(src),
    .irq(irq), .irq_ack(irq_ack), .irq_return(irq_return));

// >>> dv/pic_core_model.sv
// core model: takes requests, runs nested routines, returns
`timescale 1ns/100ps
module pic_core_model
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire pic_pkg::pic_irq_t irq,
    input wire logic [7:0] service_len,
    output logic irq_ack,
    output logic irq_return
);
    logic [15:0] seen [$];
    int left [$];
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            left.delete();
            irq_ack <= 1'b0;
            irq_return <= 1'b0;
        end
        else if (irq_ack && irq.request)
        begin
            seen.push_back(irq.vector);
            left.push_back(int'(service_len));
            irq_ack <= 1'b0;
            irq_return <= 1'b0;
        end
        else if (left.size() > 0 && left[$] == 0)
        begin
            irq_return <= 1'b1;
            irq_ack <= 1'b0;
            void'(left.pop_back());
        end
        else
        begin
            if (left.size() > 0)
                left[$] = left[$] - 1;
            irq_ack <= irq.request && !irq_ack;
            irq_return <= 1'b0;
        end
    end
endmodule

// >>> dv/test_priority_interrupt_controller.sv
// testbench: registers, vectors, gating and priority of the controller
`timescale 1ns/100ps
`define CHK(what, e, g) \
    begin \
        samples_checked++; \
        if ((g) !== (e)) \
        begin \
            fail_count++; \
            $display("ERROR %s expected %h seen %h", what, e, g); \
        end \
    end
module test_priority_interrupt_controller;
    localparam logic [15:0] IDLE = 16'hC080;
    localparam logic [15:0] VEC [16] = '{16'h006B, 16'h0063, 16'h005B,
        16'h0053, 16'h0053, 16'h004B, 16'h0043, 16'h0013, 16'h0023,
        16'h0023, 16'h002B, 16'h002B, 16'h001B, 16'h000B, 16'h0003,
        16'h0033};
    localparam logic [7:0] ADR [5] = '{8'hA6, 8'hA8, 8'hA9, 8'hB8, 8'hB9};
    localparam logic [7:0] MSK [5] = '{8'h03, 8'hBF, 8'h3F, 8'hBF, 8'h3F};
    localparam logic [7:0] RSTV [5] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    pic_pkg::pic_bus_t bus = '0;
    logic [7:0] reg_rdata;
    logic [15:0] stim = IDLE;
    pic_pkg::pic_irq_t irq;
    logic irq_ack;
    logic irq_return;
    logic [7:0] service_len = 8'h08;
    int fail_count = 0;
    int samples_checked = 0;
    int seed = 59162;
    int i;
    logic [7:0] d;
    logic [7:0] shadow [5];

    always #10 ref_clk = ~ref_clk;

    pic_controller i_pic_controller (.ref_clk(ref_clk), .rst(rst),
        .bus(bus), .reg_rdata(reg_rdata), .port_pin_a(stim[14]),
        .port_pin_b(stim[15]), .src(stim[13:0]), .irq(irq),
        .irq_ack(irq_ack), .irq_return(irq_return));
    pic_core_model i_pic_core_model (.ref_clk(ref_clk), .rst(rst),
        .irq(irq), .service_len(service_len), .irq_ack(irq_ack),
        .irq_return(irq_return));

    // ========================================================
    // tasks
    function automatic int xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus <= '0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus <= '0;
        #1;
        `CHK("reg_rdata", e, reg_rdata)
        @(posedge ref_clk);
    endtask
    task automatic expect_vec(input logic [15:0] e);
        int k;
        logic [15:0] got;
        got = 16'hXXXX;
        for (k = 0; k < 80 && i_pic_core_model.seen.size() == 0; k++)
            @(posedge ref_clk);
        if (i_pic_core_model.seen.size() > 0)
            got = i_pic_core_model.seen.pop_front();
        `CHK("vector", e, got)
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ========================================================
    // main sequence
    initial
    begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        for (i = 0; i < 5; i++)
            rd(ADR[i], RSTV[i]);
        rd(8'h55, 8'h00);
        rd(8'hC0, 8'h00);
        for (i = 0; i < 15; i++)
        begin
            d = 8'(xs());
            shadow[i % 5] = d & MSK[i % 5];
            wr(ADR[i % 5], d);
            rd(ADR[i % 5], shadow[i % 5]);
        end
        for (i = 0; i < 5; i++)
            rd(ADR[i], shadow[i]);
        wr(8'hA8, 8'h3F);
        wr(8'hB8, 8'hBF);
        wr(8'hA6, 8'h03);
        wr(8'hA9, 8'h00);
        wr(8'hB9, 8'h00);
        stim <= IDLE ^ 16'h0002;
        repeat (6) @(posedge ref_clk);
        #1;
        `CHK("request", 1'b0, irq.request)
        @(posedge ref_clk);
        rd(8'hC0, 8'h10);
        stim <= IDLE;
        wr(8'hA8, 8'hBF);
        expect_vec(16'h0063);
        rd(8'hC0, 8'h00);
        wr(8'hB8, 8'h00);
        stim <= IDLE ^ 16'h0001;
        repeat (4) @(posedge ref_clk);
        rd(8'hC0, 8'h20);
        stim <= IDLE;
        wr(8'hC0, 8'h00);
        wr(8'hB8, 8'hBF);
        repeat (12) @(posedge ref_clk);
        `CHK("stray", 0, i_pic_core_model.seen.size())
        for (i = 0; i < 16; i++)
        begin
            stim <= IDLE ^ (16'h0001 << i);
            @(posedge ref_clk);
            expect_vec(VEC[i]);
            stim <= IDLE;
            repeat (3) @(posedge ref_clk);
            wr(8'hC0, 8'h00);
            repeat (12) @(posedge ref_clk);
        end
        stim <= IDLE ^ 16'h3000;
        @(posedge ref_clk);
        expect_vec(16'h000B);
        stim <= IDLE ^ 16'h1000;
        expect_vec(16'h001B);
        stim <= IDLE;
        wr(8'hA9, 8'h10);
        wr(8'hB9, 8'h10);
        stim <= IDLE ^ 16'h2002;
        @(posedge ref_clk);
        expect_vec(16'h0063);
        expect_vec(16'h000B);
        stim <= IDLE;
        repeat (12) @(posedge ref_clk);
        service_len <= 8'h28;
        stim <= IDLE ^ 16'h2000;
        @(posedge ref_clk);
        expect_vec(16'h000B);
        stim <= IDLE ^ 16'h0002;
        @(posedge ref_clk);
        expect_vec(16'h0063);
        `CHK("depth", 2, i_pic_core_model.left.size())
        stim <= IDLE;
        repeat (100) @(posedge ref_clk);
        `CHK("stray", 0, i_pic_core_model.seen.size())
        complete_run();
    end

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        complete_run();
    end
endmodule
